/* core/digital_io_with_counter_image.sv */
// Integrated 16-in/16-out digital I/O with three counter channels and its image.
// Assumes a 10 MHz core clock, asynchronous field pins and single-cycle access strobes.
//
// Summary of operation
// RL1: Input bytes read at addresses 124, 125.
// RL2: Output bytes written at addresses 124, 125.
// RL3: Counter values at 768/772/776; 780 reserved.
// RL4: One double word per counter channel.
// RL5: Image areas sit at fixed default addresses.
// RL6: All sixteen inputs may carry interrupts.
// RL7: Interrupt on chosen rising or falling edge.
// RL8: Diagnostic interrupt only for lost interrupt.
// RL9: Delay per group of four: 0.1ms or 0.35ms.
// RL10: Counter-owned inputs remain readable in image.
// RL11: Writes to counter-owned outputs are ignored.
// RL12: Counters handle 30kHz regardless of channel count.
// RL13: Channel zero pins 0.0-0.2, 1.4, out 0.0.
// RL14: Channels one, two use their own pins.
// RL15: End or start value bounds single/periodic counting.
// RL16: One status lamp per input and output.
// RL17: Fault lamp on output overload or short.
// RL18: Outputs follow image unless counter owns them.
// RL19: Hardware gate edges combine with software gate.
// RL20: Latch rising edge stores current count.
// RL21: Image reads return filtered synchronised levels.
`default_nettype none

module digital_io_with_counter_image #(
  parameter int NUM_CH = 3
) (
  // Clock, reset, enable
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // Field pins
  input  wire logic [15:0]                 field_in_i,
  input  wire logic                        out_fault_i,
  output logic      [15:0]                 field_out_o,
  // Peripheral access: reads hit the input area, writes the output area
  input  wire logic [dio_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic                        rd_i,
  input  wire logic                        wr_i,
  input  wire logic [7:0]                  wr_data_i,
  output logic      [31:0]                 rd_data_o,
  output logic                             rd_valid_o,
  // Input configuration
  input  wire logic [15:0]                 irq_en_i,
  input  wire logic [15:0]                 irq_rising_i,
  input  wire logic [15:0]                 irq_ack_i,
  input  wire logic [3:0]                  delay_short_i,
  // Counter configuration
  input  wire logic [NUM_CH-1:0]           cnt_owns_out_i,
  input  wire logic [NUM_CH-1:0]           cnt_hardware_gate_input_en_i,
  input  wire logic [NUM_CH-1:0]           cnt_software_gate_i,
  input  wire logic [NUM_CH-1:0]           cnt_count_down_i,
  input  wire dio_pkg::cnt_mode_t          cnt_mode_i [NUM_CH],
  input  wire logic [NUM_CH-1:0][31:0]     cnt_end_value_i,
  input  wire logic [NUM_CH-1:0][31:0]     cnt_cmp_value_i,
  // Interrupts
  output logic                             hw_irq_o,
  output logic      [15:0]                 irq_pend_o,
  output logic                             diag_irq_o,
  // Counter latch results
  output logic      [NUM_CH-1:0][31:0]     latch_value_o,
  // Status lamps
  output logic      [15:0]                 in_led_o,
  output logic      [15:0]                 out_led_o,
  output logic                             fault_led_o
);
  import dio_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 3");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("address width too small for the counter area");
  end

  // ****************************************************************
  // Input synchronisation and delay filter
  // ****************************************************************
  logic [15:0] di_sync;
  logic [15:0] di_filt;
  logic        fault_level;

  // Counter pins use the synchronised level, not the delay filter, so that a
  // 30 kHz pulse train still counts whatever delay the group has selected.
  for (genvar i = 0; i < 16; i++) begin : g_in
    input_filter u_filt (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .pin_i      (field_in_i[i]),
      .short_i    (delay_short_i[i/4]),                          // [RL9]
      .sync_o     (di_sync[i]),
      .level_o    (di_filt[i])
    );
  end

  input_filter u_fault_filt (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .pin_i      (out_fault_i),
    .short_i    (1'b1),
    .sync_o     (),
    .level_o    (fault_level)
  );

  // ****************************************************************
  // Counter channels
  // ****************************************************************
  counter_if          cif [NUM_CH] ();
  logic signed [31:0] cnt_value [3];
  logic [2:0]         cnt_cmp;
  logic [15:0]        own_mask;

  for (genvar g = 0; g < 3; g++) begin : g_ch
    if (g < NUM_CH) begin : g_on
      assign cif[g].track_a    = di_sync[CNT_A_BIT[g]];          // [RL13] [RL14]
      assign cif[g].track_b    = di_sync[CNT_DIR_BIT[g]];        // [RL13] [RL14]
      assign cif[g].hardware_gate_input    = di_sync[CNT_GATE_BIT[g]];       // [RL13] [RL14]
      assign cif[g].latch_in   = di_sync[CNT_LATCH_BIT[g]];      // [RL13] [RL14]
      assign cif[g].hardware_gate_input_en = cnt_hardware_gate_input_en_i[g];
      assign cif[g].software_gate    = cnt_software_gate_i[g];
      assign cif[g].count_down = cnt_count_down_i[g];
      assign cif[g].mode       = cnt_mode_i[g];
      assign cif[g].end_value  = cnt_end_value_i[g];
      assign cif[g].cmp_value  = $signed(cnt_cmp_value_i[g]);
      assign cnt_value[g]      = cif[g].value;
      assign cnt_cmp[g]        = cif[g].cmp_hit;
      assign latch_value_o[g]  = cif[g].latched;
      assign own_mask[CNT_OUT_BIT[g]] = cnt_owns_out_i[g];
      counter_channel u_chan (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .cif        (cif[g])
      );
    end else begin : g_off
      assign cnt_value[g] = 32'sd0;
      assign cnt_cmp[g]   = 1'b0;
      assign own_mask[CNT_OUT_BIT[g]] = 1'b0;
    end
  end
  // Only the three lowest outputs can ever belong to a counter.
  assign own_mask[15:3] = 13'h0000;

  // ****************************************************************
  // Output image and output pins
  // ****************************************************************
  logic [15:0] do_image_reg;
  logic [15:0] do_image_next;
  logic [15:0] do_next;

  wire wr_low  = wr_i && (addr_i == DIO_LOW_OFS);                // [RL2] [RL5]
  wire wr_high = wr_i && (addr_i == DIO_HIGH_OFS);               // [RL2] [RL5]

  // Owned bits keep their old image value so that releasing a channel later
  // does not suddenly drive a stale write onto the pin.
  assign do_image_next[7:0]  = wr_low ?
    ((do_image_reg[7:0] & own_mask[7:0]) | (wr_data_i & ~own_mask[7:0])) :   // [RL11]
    do_image_reg[7:0];
  assign do_image_next[15:8] = wr_high ?
    ((do_image_reg[15:8] & own_mask[15:8]) | (wr_data_i & ~own_mask[15:8])) : // [RL11]
    do_image_reg[15:8];

  // A counter that owns its output drives it from its compare result.
  always_comb begin
    do_next = do_image_reg;                                      // [RL18]
    for (int c = 0; c < 3; c++) begin
      if (own_mask[CNT_OUT_BIT[c]]) do_next[CNT_OUT_BIT[c]] = cnt_cmp[c];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      do_image_reg <= DO_IMAGE_RST;
      field_out_o  <= DO_IMAGE_RST;
      out_led_o    <= DO_IMAGE_RST;
    end else if (ce_i) begin
      do_image_reg <= do_image_next;
      field_out_o  <= do_next;
      out_led_o    <= do_next;                                   // [RL16]
    end
  end

  // ****************************************************************
  // Input image read port
  // ****************************************************************
  logic [31:0] rd_word;

  // Every input bit is readable, counter-owned or not.
  always_comb begin
    case (addr_i)
      DIO_LOW_OFS:  rd_word = {24'h000000, di_filt[7:0]};        // [RL1] [RL10] [RL21]
      DIO_HIGH_OFS: rd_word = {24'h000000, di_filt[15:8]};       // [RL1] [RL10] [RL21]
      CNT0_OFS:     rd_word = cnt_value[0];                      // [RL3] [RL4]
      CNT1_OFS:     rd_word = cnt_value[1];                      // [RL3] [RL4]
      CNT2_OFS:     rd_word = cnt_value[2];                      // [RL3] [RL4]
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_data_o  <= 32'h0000_0000;
      rd_valid_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= rd_i;
      if (rd_i) rd_data_o <= rd_word;
    end
  end

  // ****************************************************************
  // Hardware and diagnostic interrupts
  // ****************************************************************
  logic [15:0] di_prev_reg;
  logic [15:0] irq_pend_next;

  wire [15:0] edge_hit = irq_en_i &                              // [RL6]
    ((irq_rising_i & di_filt & ~di_prev_reg) |                   // [RL7]
     (~irq_rising_i & ~di_filt & di_prev_reg));                  // [RL7]
  // An edge in the same cycle as its acknowledge re-arms the bit, not a loss.
  wire [15:0] irq_lost = edge_hit & irq_pend_o & ~irq_ack_i;     // [RL8]
  assign irq_pend_next = (irq_pend_o & ~irq_ack_i) | edge_hit;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      di_prev_reg <= 16'h0000;
      irq_pend_o  <= 16'h0000;
      hw_irq_o    <= 1'b0;
      diag_irq_o  <= 1'b0;
    end else if (ce_i) begin
      di_prev_reg <= di_filt;
      irq_pend_o  <= irq_pend_next;                              // [RL7]
      hw_irq_o    <= |irq_pend_next;
      diag_irq_o  <= |irq_lost;                                  // [RL8]
    end
  end

  // ****************************************************************
  // Status lamps
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      in_led_o    <= 16'h0000;
      fault_led_o <= 1'b0;
    end else if (ce_i) begin
      in_led_o    <= di_filt;                                    // [RL16]
      fault_led_o <= fault_level;                                // [RL17]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_owned_write_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL11]
    (ce_i && wr_low && own_mask[0]) |=> (do_image_reg[0] == $past(do_image_reg[0])))
    else $error("write reached a counter-owned output");

  a_free_out_follows: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL2] [RL18]
    (ce_i && wr_high) |=> ##1 (field_out_o[15:8] == $past(wr_data_i, 2) || !$past(ce_i)))
    else $error("high output byte did not follow the write");

  a_owned_out_cmp: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL13]
    (ce_i && own_mask[0]) |=> (field_out_o[0] == $past(cnt_cmp[0])))
    else $error("owned output not driven by counter compare");

  a_read_low_byte: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL1] [RL21]
    (ce_i && rd_i && addr_i == DIO_LOW_OFS)
      |=> (rd_valid_o && rd_data_o == {24'h000000, $past(di_filt[7:0])}))
    else $error("low input byte read returned wrong data");

  a_read_counter: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL3]
    (ce_i && rd_i && addr_i == CNT1_OFS) |=> (rd_data_o == $past(cnt_value[1])))
    else $error("counter word read returned wrong data");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL3]
    (ce_i && rd_i && addr_i == CNT_RSVD_OFS) |=> (rd_data_o == 32'h0000_0000))
    else $error("reserved counter word did not read zero");

  a_irq_on_edge: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL7]
    (ce_i && edge_hit != 16'h0000) |=> (hw_irq_o && (irq_pend_o & $past(edge_hit)) != 0))
    else $error("configured edge raised no interrupt");

  a_diag_only_lost: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL8]
    $rose(diag_irq_o) |-> $past((edge_hit & irq_pend_o & ~irq_ack_i) != 16'h0000))
    else $error("diagnostic interrupt without a lost interrupt");

  // The high byte read is held to the same timing as the low byte.
  a_read_high_byte: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL1] [RL21]
    (ce_i && rd_i && addr_i == DIO_HIGH_OFS)
      |=> (rd_valid_o && rd_data_o == {24'h000000, $past(di_filt[15:8])}))
    else $error("high input byte read returned wrong data");

  // A read answers once; a cycle without a strobe drops the valid flag.
  a_read_one_shot: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL1]
    (ce_i && !rd_i) |=> !rd_valid_o)
    else $error("read valid without a read strobe");

  // Writes outside the two output bytes land nowhere, the reserved words included.
  a_stray_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL2] [RL3]
    (ce_i && wr_i && !wr_low && !wr_high) |=> (do_image_reg == $past(do_image_reg)))
    else $error("write outside the output bytes changed the image");

  // The input and fault lamps are registered copies, one cycle behind what they show.
  a_input_lamps: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL16]
    ce_i |=> (in_led_o == $past(di_filt)))
    else $error("input lamps do not follow the filtered inputs");

  a_fault_lamp: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL17]
    ce_i |=> (fault_led_o == $past(fault_level)))
    else $error("fault lamp does not follow the fault input");

  // ****************************************************************
  // Per-channel and per-input checks
  // ****************************************************************
  // Channel words sit four bytes apart, one per channel.
  for (genvar k = 0; k < NUM_CH; k++) begin : g_cnt_chk
    a_count_word: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL3] [RL4]
      (ce_i && rd_i && addr_i == CNT0_OFS + 10'(4 * k))
        |=> (rd_data_o == $past(cnt_value[k])))
      else $error("counter word read returned wrong data");
  end

  // An acknowledge only clears a bit when no new edge arrives with it.
  for (genvar k = 0; k < 16; k++) begin : g_irq_chk
    a_ack_clears: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL7]
      (ce_i && irq_ack_i[k] && !edge_hit[k]) |=> !irq_pend_o[k])
      else $error("acknowledge left the interrupt pending");

    a_pend_holds: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL7]
      (ce_i && irq_pend_o[k] && !irq_ack_i[k]) |=> irq_pend_o[k])
      else $error("pending interrupt dropped without acknowledge");
  end
endmodule

`default_nettype wire

/* include/dio_pkg.sv */
// Shared constants for the integrated digital I/O and counter image block.
// Assumes a single 10 MHz core clock and the fixed default peripheral map.
`default_nettype none

package dio_pkg;

  // ****************************************************************
  // Clock and input delay timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          FILT_SHORT_NS  = 100_000;
  localparam int          FILT_LONG_NS   = 350_000;
  localparam int          FILT_CNT_W     = 12;
  localparam logic [11:0] FILT_SHORT_CYC =
    12'((FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] FILT_LONG_CYC  =
    12'((FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          CNT_MAX_HZ     = 30_000;

  // ****************************************************************
  // Peripheral address map
  // ****************************************************************
  localparam int          ADDR_W         = 10;
  localparam logic [9:0]  DIO_LOW_OFS    = 10'h07c;
  localparam logic [9:0]  DIO_HIGH_OFS   = 10'h07d;
  localparam logic [9:0]  CNT0_OFS       = 10'h300;
  localparam logic [9:0]  CNT1_OFS       = 10'h304;
  localparam logic [9:0]  CNT2_OFS       = 10'h308;
  localparam logic [9:0]  CNT_RSVD_OFS   = 10'h30c;
  localparam logic [15:0] DO_IMAGE_RST   = 16'h0000;
  localparam logic [31:0] END_VALUE_DEF  = 32'h7fff_ffff;

  // ****************************************************************
  // Counter channel pin mapping
  // ****************************************************************
  localparam int CNT_A_BIT     [3] = '{0, 3, 6};
  localparam int CNT_DIR_BIT   [3] = '{1, 4, 7};
  localparam int CNT_GATE_BIT  [3] = '{2, 5, 8};
  localparam int CNT_LATCH_BIT [3] = '{12, 13, 14};
  localparam int CNT_OUT_BIT   [3] = '{0, 1, 2};

  typedef enum logic [1:0] {MODE_CONTINUOUS, MODE_SINGLE, MODE_PERIODIC} cnt_mode_t;

endpackage

`default_nettype wire

/* include/counter_if.sv */
// Signals between the top block and one counter channel.
// Assumes all members are driven in the core clock domain.
`default_nettype none

interface counter_if;
  logic                    track_a;
  logic                    track_b;
  logic                    hardware_gate_input;
  logic                    latch_in;
  logic                    hardware_gate_input_en;
  logic                    software_gate;
  logic                    count_down;
  dio_pkg::cnt_mode_t      mode;
  logic [31:0]             end_value;
  logic signed [31:0]      cmp_value;
  logic signed [31:0]      value;
  logic signed [31:0]      latched;
  logic                    cmp_hit;
  modport top  (output track_a, track_b, hardware_gate_input, latch_in, hardware_gate_input_en, software_gate,
                count_down, mode, end_value, cmp_value,
                input value, latched, cmp_hit);
  modport chan (input track_a, track_b, hardware_gate_input, latch_in, hardware_gate_input_en, software_gate,
                count_down, mode, end_value, cmp_value,
                output value, latched, cmp_hit);
endinterface

`default_nettype wire

/* core/input_filter.sv */
// One digital input: three-stage synchroniser and input delay filter.
// Assumes an asynchronous field level on pin_i.
`default_nettype none

module input_filter (
  // Clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Pin and delay select
  input  wire logic pin_i,
  input  wire logic short_i,
  // Results
  output logic      sync_o,
  output logic      level_o
);
  import dio_pkg::*;

  logic                  s1_reg, s2_reg, s3_reg;
  logic [FILT_CNT_W-1:0] cnt_reg;
  wire  [FILT_CNT_W-1:0] limit = short_i ? FILT_SHORT_CYC : FILT_LONG_CYC;
  wire                   agree = (s2_reg == s3_reg);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {s1_reg, s2_reg, s3_reg, sync_o, level_o} <= 5'h00;
      cnt_reg <= '0;
    end else if (ce_i) begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) sync_o <= s3_reg;
      if (agree && s3_reg != level_o) begin
        if (cnt_reg == limit - 12'h001) begin
          level_o <= s3_reg;
          cnt_reg <= '0;
        end else cnt_reg <= cnt_reg + 12'h001;
      end else cnt_reg <= '0;
    end
  end
endmodule

`default_nettype wire

/* core/counter_channel.sv */
// One counter channel: gate, count, range limit, latch and compare.
// Assumes its inputs are already synchronised to the core clock.
`default_nettype none

module counter_channel (
  // Clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Channel signals
  counter_if.chan   cif
);
  import dio_pkg::*;

  logic               a_prev_reg, gate_prev_reg, latch_prev_reg, hardware_gate_input_reg, done_reg;
  logic               cmp_reg;
  logic signed [31:0] value_reg, value_next, latched_reg;

  wire                a_rise     = cif.track_a & ~a_prev_reg;
  wire                latch_rise = cif.latch_in & ~latch_prev_reg;
  wire                gate_open  = cif.software_gate & ~done_reg & (~cif.hardware_gate_input_en | hardware_gate_input_reg);
  wire                step       = a_rise & gate_open;
  wire                bounded    = (cif.mode != MODE_CONTINUOUS);
  wire signed [31:0]  end_val    = $signed(cif.end_value);
  wire                up_wrap    = bounded & ~cif.count_down & ~cif.track_b &
                                   (value_reg == end_val - 32'sd1);
  wire                dn_wrap    = bounded & cif.count_down & cif.track_b &
                                   (value_reg == 32'sd1);

  always_comb begin
    value_next = value_reg;
    if (step) begin
      if (up_wrap) value_next = 32'sd0;                          // [RL15]
      else if (dn_wrap) value_next = end_val;                    // [RL15]
      else if (cif.track_b) value_next = value_reg - 32'sd1;
      else value_next = value_reg + 32'sd1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      {a_prev_reg, gate_prev_reg, latch_prev_reg, hardware_gate_input_reg, done_reg, cmp_reg} <= 6'h00;
      value_reg   <= 32'sd0;
      latched_reg <= 32'sd0;
    end else if (ce_i) begin
      a_prev_reg     <= cif.track_a;
      gate_prev_reg  <= cif.hardware_gate_input;
      latch_prev_reg <= cif.latch_in;
      if (cif.hardware_gate_input & ~gate_prev_reg) hardware_gate_input_reg <= 1'b1;     // [RL19]
      else if (~cif.hardware_gate_input & gate_prev_reg) hardware_gate_input_reg <= 1'b0;
      if (!cif.software_gate) done_reg <= 1'b0;
      else if (step && (up_wrap || dn_wrap) && cif.mode == MODE_SINGLE) done_reg <= 1'b1;
      value_reg <= value_next;                                   // [RL12]
      if (latch_rise) latched_reg <= value_reg;                  // [RL20]
      cmp_reg <= (value_reg >= cif.cmp_value);
    end
  end

  assign cif.value   = value_reg;
  assign cif.latched = latched_reg;
  assign cif.cmp_hit = cmp_reg;

  a_latch_capture: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL20]
    (ce_i && latch_rise) |=> (latched_reg == $past(value_reg)))
    else $error("latch did not capture the count value");
  a_gate_closed_hold: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL19]
    (ce_i && !gate_open) |=> (value_reg == $past(value_reg)))
    else $error("counter moved with the gate closed");
  a_up_range_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL15]
    (ce_i && step && up_wrap) |=> (value_reg == 32'sd0))
    else $error("up count did not wrap at end value");
endmodule

`default_nettype wire

/* testbench/field_model.sv */
// Field side model: sensors and encoder tracks on the input pins, output fault line.
// Assumes it is driven by task calls from the bench, changing pins after rising edges.
`default_nettype none

module field_model (
  // Clock
  input  wire logic        core_clk_i,
  // Field lines
  output logic      [15:0] pins_o,
  output logic             fault_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    pins_o  = 16'h0000;
    fault_o = 1'b0;
  end

  task automatic drive(input logic [15:0] v, input logic f);
    @(posedge core_clk_i);
    pins_o  <= v;
    fault_o <= f;
  endtask

  // Half period of 170 cycles keeps the pulse rate just under 30 kHz.
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      pins_o[b] <= 1'b1;
      repeat (170) @(posedge core_clk_i);
      pins_o[b] <= 1'b0;
      repeat (170) @(posedge core_clk_i);
    end
  endtask
endmodule

`default_nettype wire

/* testbench/digital_io_with_counter_image_tb_top.sv */
// Self-checking bench for the digital I/O and counter image block.
// Assumes the field model drives the pins and the bench owns the access strobes.
`default_nettype none

module digital_io_with_counter_image_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dio_pkg::*;

  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [15:0]       pins;
  logic              fault;
  logic [9:0]        addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [7:0]        wdat = '0;
  logic [31:0]       rdat;
  logic              rvld;
  logic [15:0]       irq_en = 16'h8030;
  logic [15:0]       irq_rise = 16'h8010;
  logic [15:0]       ack = '0;
  logic [2:0]        owns = '0;
  logic [2:0]        software_gate = '0;
  logic [2:0][31:0]  cmp_v = {32'h7fff_ffff, 32'h7fff_ffff, 32'h0000_0003};
  cnt_mode_t         modes [3] = '{MODE_CONTINUOUS, MODE_CONTINUOUS, MODE_PERIODIC};
  logic [15:0]       fout, iled, oled, pend;
  logic              hw_irq, diag, fled, diag_seen = 1'b0;
  logic [2:0][31:0]  latv;
  int                fail_count = 0;
  int                n_tests = 0;
  int                cyc = 0;

  always #50 core_clk_i = ~core_clk_i;

  field_model FM (.core_clk_i(core_clk_i), .pins_o(pins), .fault_o(fault));

  digital_io_with_counter_image DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .field_in_i(pins),
    .out_fault_i(fault), .field_out_o(fout), .addr_i(addr), .rd_i(rd), .wr_i(wr),
    .wr_data_i(wdat), .rd_data_o(rdat), .rd_valid_o(rvld), .irq_en_i(irq_en),
    .irq_rising_i(irq_rise), .irq_ack_i(ack), .delay_short_i(4'b0111),
    .cnt_owns_out_i(owns), .cnt_hardware_gate_input_en_i(3'b100), .cnt_software_gate_i(software_gate),
    .cnt_count_down_i(3'b000), .cnt_mode_i(modes),
    .cnt_end_value_i({32'h0000_0002, END_VALUE_DEF, END_VALUE_DEF}),
    .cnt_cmp_value_i(cmp_v), .hw_irq_o(hw_irq), .irq_pend_o(pend), .diag_irq_o(diag),
    .latch_value_o(latv), .in_led_o(iled), .out_led_o(oled), .fault_led_o(fled));

  // The lost-interrupt pulse lasts one cycle, so it is caught in a sticky flag.
  always @(posedge core_clk_i) begin
    if (diag === 1'b1) diag_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_b(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    chk({31'h0, rvld}, 32'h1);
    chk(rdat, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wr_b(10'h07c, 8'h5a);
    wr_b(10'h07d, 8'hc3);
    wr_b(10'h300, 8'hff);
    wt(2);
    chk({16'h0, fout}, 32'h0000_c35a);
    chk({16'h0, oled}, 32'h0000_c35a);
    @(posedge core_clk_i);
    owns <= 3'b001;
    wr_b(10'h07c, 8'h01);
    wt(2);
    chk({16'h0, fout}, 32'h0000_c300);
    FM.drive(16'h0020, 1'b1);
    wt(1200);
    rd_chk(10'h07c, 32'h20);
    chk({16'h0, iled}, 32'h0020);
    chk({31'h0, fled}, 32'h1);
    chk({16'h0, pend}, 32'h0);
    FM.drive(16'h8010, 1'b0);
    rd_chk(10'h07c, 32'h20);
    wt(1200);
    rd_chk(10'h07c, 32'h10);
    rd_chk(10'h07d, 32'h00);
    chk({31'h0, fled}, 32'h0);
    chk({16'h0, pend}, 32'h0030);
    wt(2500);
    rd_chk(10'h07d, 32'h80);
    chk({16'h0, pend}, 32'h8030);
    chk({31'h0, hw_irq}, 32'h1);
    chk({31'h0, diag_seen}, 32'h0);
    @(posedge core_clk_i);
    ack <= 16'h0020;
    @(posedge core_clk_i);
    ack <= 16'h0000;
    wt(2);
    chk({16'h0, pend}, 32'h8010);
    FM.drive(16'h8000, 1'b0);
    wt(1200);
    FM.drive(16'h8010, 1'b0);
    wt(1200);
    chk({31'h0, diag_seen}, 32'h1);
    @(posedge core_clk_i);
    software_gate <= 3'b101;
    FM.pulse(0, 3);
    wt(20);
    rd_chk(10'h300, 32'd3);
    chk({16'h0, fout}, 32'h0000_c301);
    rd_chk(10'h304, 32'd0);
    rd_chk(10'h30c, 32'd0);
    FM.drive(16'h9010, 1'b0);
    wt(20);
    chk(latv[0], 32'd3);
    FM.pulse(6, 3);
    wt(20);
    rd_chk(10'h308, 32'd0);
    FM.drive(16'h9110, 1'b0);
    FM.pulse(6, 3);
    wt(20);
    rd_chk(10'h308, 32'd1);
    @(posedge core_clk_i);
    owns <= 3'b000;
    wt(2);
    chk({16'h0, fout}, 32'h0000_c300);
    end_sim();
  end
endmodule

`default_nettype wire
